// ==== rtl/sfl_fifo.v ====
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module sfl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clock,
  input wire rst_n,
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;
  localparam integer FULL_I = DEPTH;
  localparam integer LAST_I = DEPTH - 1;
  localparam [AW:0] FULL_COUNT = FULL_I[AW:0];
  localparam [AW-1:0] LAST_PTR = LAST_I[AW-1:0];

  assign in_ready = (count_reg != FULL_COUNT);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_entry
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          mem_reg[g] <= {WIDTH{1'b0}};
        end else if (push && wr_ptr_reg == g) begin
          mem_reg[g] <= in_data;
        end
      end
    end
  endgenerate

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? {AW{1'b0}} :
                      wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? {AW{1'b0}} :
                      rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // sfl_fifo

// ==== rtl/sfl_framer.v ====
// serial link framer: checks splice requests, sends inject replies
//
// Contract
// - send inject-complete about half a second after inject response.
// - inject-complete carries code 0008, size 000f, two data bytes.
// - complete byte 13 echoes request number, byte 14 its op count.
// - result 0064 normally, 0080 when acting as proxy.
// - protocol version byte 8 zero, result extension word 6 zero.
// - complete's own message number is fresh, unlike request number.
// - each serial frame begins with start delimiter 02.
// - each serial frame ends with end delimiter 03 after the crc.
// - body bytes equal to 02 or 03 get escape 1b before them.
// - frame is message plus delimiters, escapes and 32-bit crc.
// - multi-op request answered with 0007, size 000e, number echo.
// - timestamp type zero means no time, one byte only.
`timescale 1ns/1ps
`include "sfl_regs.vh"
module sfl_framer #(
  parameter DONE_CYCLES = `SFL_DONE_CYCLES,
  parameter CNT_W = 23,
  parameter [7:0] TS_EXTRA = 8'h01,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  input wire clock,
  input wire rst_n,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire proxy_mode,
  output reg [7:0] tx_data,
  output reg tx_valid,
  input wire tx_ready,
  output reg rx_frame_ok,
  output reg rx_frame_err
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_BODY = 3'd2;
  localparam [2:0] ST_CRC = 3'd3;
  localparam [2:0] ST_END = 3'd4;
  localparam integer DONE_LAST_I = DONE_CYCLES - 1;
  localparam [CNT_W-1:0] DONE_LAST = DONE_LAST_I[CNT_W-1:0];
  localparam [15:0] OP_RESP = `SFL_OP_INJ_RESP;
  localparam [15:0] OP_DONE = `SFL_OP_INJ_DONE;
  localparam [15:0] SIZE_RESP = `SFL_SIZE_RESP;
  localparam [15:0] SIZE_DONE = `SFL_SIZE_DONE;
  localparam [15:0] RES_OK = `SFL_RES_OK;
  localparam [15:0] RES_PROXY = `SFL_RES_PROXY;
  localparam [15:0] RES_EXT = `SFL_RES_EXT;
  localparam [3:0] RESP_LAST = 4'hd;
  localparam [3:0] DONE_LAST_IDX = 4'he;

  function [31:0] crc_upd;
    input [31:0] c;
    input [7:0] d;
    integer i;
    reg [31:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (r[31] ^ d[7-i]) begin
          r = {r[30:0], 1'b0} ^ `SFL_CRC_POLY;
        end else begin
          r = {r[30:0], 1'b0};
        end
      end
      crc_upd = r;
    end
  endfunction

  // receive side
  reg rx_in_frame_reg;
  reg rx_esc_reg;
  reg [7:0] rx_idx_reg;
  reg [31:0] rx_crc_reg;
  reg [15:0] rx_op_reg;
  reg [7:0] rx_as_reg;
  reg [7:0] rx_num_reg;
  reg [15:0] rx_dpi_reg;
  reg [7:0] rx_ts_reg;
  reg [7:0] rx_ops_reg;
  // latched request waiting for its inject response
  reg resp_pend_reg;
  reg [7:0] req_as_reg;
  reg [7:0] req_num_reg;
  reg [15:0] req_dpi_reg;
  reg [7:0] req_ops_reg;
  // transmit snapshot
  reg [2:0] tx_state_reg;
  reg tx_kind_reg;
  reg [3:0] tx_idx_reg;
  reg tx_esc_reg;
  reg [31:0] tx_crc_reg;
  reg [7:0] tx_as_reg;
  reg [7:0] tx_num_reg;
  reg [15:0] tx_dpi_reg;
  reg [7:0] tx_d13_reg;
  reg [7:0] tx_ops_reg;
  reg tx_proxy_reg;
  // pending inject-complete
  reg done_run_reg;
  reg done_pend_reg;
  reg [CNT_W-1:0] done_cnt_reg;
  reg [7:0] done_as_reg;
  reg [7:0] done_req_reg;
  reg [15:0] done_dpi_reg;
  reg [7:0] done_ops_reg;
  reg [7:0] seq_reg;

  wire [7:0] nops_idx;
  wire rx_literal;
  wire [31:0] rx_crc_next;
  wire frame_good;
  wire [7:0] fresh_num;
  reg [7:0] body_byte;
  reg [7:0] cur_byte;
  reg [7:0] push_data;
  reg push_valid;
  wire push_ready;
  wire push_fire;
  wire need_esc;
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire fifo_take;

  assign nops_idx = (rx_ts_reg == `SFL_TS_NONE) ? `SFL_RX_OFF_NOPS :
                    `SFL_RX_OFF_NOPS + TS_EXTRA;
  assign rx_literal = rx_valid && rx_in_frame_reg &&
    (rx_esc_reg || (rx_data != `SFL_ESC_BYTE &&
     rx_data != `SFL_END_BYTE && rx_data != `SFL_START_BYTE));
  assign rx_crc_next = crc_upd(rx_crc_reg, rx_data);
  assign frame_good = (rx_crc_reg == `SFL_CRC_RESIDUE) &&
                      (rx_idx_reg >= `SFL_RX_MIN_LEN);
  assign fresh_num = (seq_reg == done_req_reg) ?
                     seq_reg + 8'h01 : seq_reg;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_in_frame_reg <= 1'b0;
      rx_esc_reg <= 1'b0;
      rx_idx_reg <= 8'h00;
      rx_crc_reg <= `SFL_CRC_INIT;
      rx_op_reg <= 16'h0000;
      rx_as_reg <= 8'h00;
      rx_num_reg <= 8'h00;
      rx_dpi_reg <= 16'h0000;
      rx_ts_reg <= 8'h00;
      rx_ops_reg <= 8'h00;
      rx_frame_ok <= 1'b0;
      rx_frame_err <= 1'b0;
      req_as_reg <= 8'h00;
      req_num_reg <= 8'h00;
      req_dpi_reg <= 16'h0000;
      req_ops_reg <= 8'h00;
    end else begin
      rx_frame_ok <= 1'b0;
      rx_frame_err <= 1'b0;
      if (rx_valid) begin
        if (!rx_in_frame_reg || (!rx_esc_reg &&
            rx_data == `SFL_START_BYTE)) begin
          if (rx_data == `SFL_START_BYTE) begin
            rx_in_frame_reg <= 1'b1;
            rx_esc_reg <= 1'b0;
            rx_idx_reg <= 8'h00;
            rx_crc_reg <= `SFL_CRC_INIT;
            rx_ts_reg <= 8'h00;
          end
        end else if (rx_literal) begin
          rx_esc_reg <= 1'b0;
          rx_crc_reg <= rx_crc_next;
          if (rx_idx_reg != 8'hff) begin
            rx_idx_reg <= rx_idx_reg + 8'h01;
          end
          if (rx_idx_reg == `SFL_RX_OFF_OP_HI) rx_op_reg[15:8] <= rx_data;
          if (rx_idx_reg == `SFL_RX_OFF_OP_LO) rx_op_reg[7:0] <= rx_data;
          if (rx_idx_reg == `SFL_RX_OFF_AS) rx_as_reg <= rx_data;
          if (rx_idx_reg == `SFL_RX_OFF_NUM) rx_num_reg <= rx_data;
          if (rx_idx_reg == `SFL_RX_OFF_DPI_HI) rx_dpi_reg[15:8] <= rx_data;
          if (rx_idx_reg == `SFL_RX_OFF_DPI_LO) rx_dpi_reg[7:0] <= rx_data;
          if (rx_idx_reg == `SFL_RX_OFF_TS) rx_ts_reg <= rx_data;
          if (rx_idx_reg == nops_idx) rx_ops_reg <= rx_data;
        end else if (rx_data == `SFL_ESC_BYTE) begin
          rx_esc_reg <= 1'b1;
        end else begin
          rx_in_frame_reg <= 1'b0;
          if (!frame_good) begin
            rx_frame_err <= 1'b1;
          end else if (rx_op_reg == `SFL_OP_MULTI) begin
            rx_frame_ok <= 1'b1;
            req_as_reg <= rx_as_reg;
            req_num_reg <= rx_num_reg;
            req_dpi_reg <= rx_dpi_reg;
            req_ops_reg <= rx_ops_reg;
          end
        end
      end
    end
  end

  // reply message bytes by offset
  always @* begin
    body_byte = 8'h00;
    case (tx_idx_reg)
      4'h0: body_byte = tx_kind_reg ? OP_DONE[15:8] :
                        OP_RESP[15:8];
      4'h1: body_byte = tx_kind_reg ? OP_DONE[7:0] :
                        OP_RESP[7:0];
      4'h2: body_byte = tx_kind_reg ? SIZE_DONE[15:8] :
                        SIZE_RESP[15:8];
      4'h3: body_byte = tx_kind_reg ? SIZE_DONE[7:0] :
                        SIZE_RESP[7:0];
      4'h4: body_byte = tx_proxy_reg ? RES_PROXY[15:8] :
                        RES_OK[15:8];
      4'h5: body_byte = tx_proxy_reg ? RES_PROXY[7:0] :
                        RES_OK[7:0];
      `SFL_TX_OFF_RES_EXT: body_byte = RES_EXT[15:8];
      4'h7: body_byte = RES_EXT[7:0];
      `SFL_TX_OFF_VER: body_byte = `SFL_PROTO_VER;
      4'h9: body_byte = tx_as_reg;
      `SFL_TX_OFF_NUM: body_byte = tx_num_reg;
      4'hb: body_byte = tx_dpi_reg[15:8];
      4'hc: body_byte = tx_dpi_reg[7:0];
      `SFL_TX_OFF_DATA0: body_byte = tx_d13_reg;
      `SFL_TX_OFF_DATA1: body_byte = tx_ops_reg;
      default: body_byte = 8'h00;
    endcase
  end

  assign need_esc = (cur_byte == `SFL_START_BYTE) ||
                    (cur_byte == `SFL_END_BYTE) ||
                    (cur_byte == `SFL_ESC_BYTE);

  always @* begin
    cur_byte = (tx_state_reg == ST_CRC) ? tx_crc_reg[31:24] : body_byte;
    push_valid = 1'b0;
    push_data = 8'h00;
    case (tx_state_reg)
      ST_START: begin
        push_valid = 1'b1;
        push_data = `SFL_START_BYTE;
      end
      ST_BODY, ST_CRC: begin
        push_valid = 1'b1;
        push_data = (need_esc && !tx_esc_reg) ? `SFL_ESC_BYTE :
                    cur_byte;
      end
      ST_END: begin
        push_valid = 1'b1;
        push_data = `SFL_END_BYTE;
      end
      default: push_valid = 1'b0;
    endcase
  end

  assign push_fire = push_valid && push_ready;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= ST_IDLE;
      tx_kind_reg <= 1'b0;
      tx_idx_reg <= 4'h0;
      tx_esc_reg <= 1'b0;
      tx_crc_reg <= `SFL_CRC_INIT;
      tx_as_reg <= 8'h00;
      tx_num_reg <= 8'h00;
      tx_dpi_reg <= 16'h0000;
      tx_d13_reg <= 8'h00;
      tx_ops_reg <= 8'h00;
      tx_proxy_reg <= 1'b0;
      resp_pend_reg <= 1'b0;
      done_run_reg <= 1'b0;
      done_pend_reg <= 1'b0;
      done_cnt_reg <= {CNT_W{1'b0}};
      done_as_reg <= 8'h00;
      done_req_reg <= 8'h00;
      done_dpi_reg <= 16'h0000;
      done_ops_reg <= 8'h00;
      seq_reg <= 8'h00;
    end else begin
      case (tx_state_reg)
        ST_IDLE: begin
          tx_proxy_reg <= proxy_mode;
          if (resp_pend_reg) begin
            resp_pend_reg <= 1'b0;
            tx_kind_reg <= 1'b0;
            tx_as_reg <= req_as_reg;
            tx_num_reg <= req_num_reg;
            tx_dpi_reg <= req_dpi_reg;
            tx_d13_reg <= req_num_reg;
            tx_ops_reg <= req_ops_reg;
            tx_state_reg <= ST_START;
          end else if (done_pend_reg) begin
            done_pend_reg <= 1'b0;
            tx_kind_reg <= 1'b1;
            tx_as_reg <= done_as_reg;
            tx_num_reg <= fresh_num;
            seq_reg <= fresh_num + 8'h01;
            tx_dpi_reg <= done_dpi_reg;
            tx_d13_reg <= done_req_reg;
            tx_ops_reg <= done_ops_reg;
            tx_state_reg <= ST_START;
          end
        end
        ST_START: begin
          if (push_fire) begin
            tx_idx_reg <= 4'h0;
            tx_esc_reg <= 1'b0;
            tx_crc_reg <= `SFL_CRC_INIT;
            tx_state_reg <= ST_BODY;
          end
        end
        ST_BODY: begin
          if (push_fire) begin
            if (need_esc && !tx_esc_reg) begin
              tx_esc_reg <= 1'b1;
            end else begin
              tx_esc_reg <= 1'b0;
              tx_crc_reg <= crc_upd(tx_crc_reg, cur_byte);
              if (tx_idx_reg == (tx_kind_reg ? DONE_LAST_IDX : RESP_LAST))
              begin
                tx_idx_reg <= 4'h0;
                tx_state_reg <= ST_CRC;
              end else begin
                tx_idx_reg <= tx_idx_reg + 4'h1;
              end
            end
          end
        end
        ST_CRC: begin
          if (push_fire) begin
            if (need_esc && !tx_esc_reg) begin
              tx_esc_reg <= 1'b1;
            end else begin
              tx_esc_reg <= 1'b0;
              tx_crc_reg <= {tx_crc_reg[23:0], 8'h00};
              tx_idx_reg <= tx_idx_reg + 4'h1;
              if (tx_idx_reg == 4'h3) begin
                tx_state_reg <= ST_END;
              end
            end
          end
        end
        ST_END: begin
          if (push_fire) begin
            tx_state_reg <= ST_IDLE;
            if (!tx_kind_reg) begin
              done_run_reg <= 1'b1;
              done_cnt_reg <= {CNT_W{1'b0}};
              done_as_reg <= tx_as_reg;
              done_req_reg <= tx_num_reg;
              done_dpi_reg <= tx_dpi_reg;
              done_ops_reg <= tx_ops_reg;
            end
          end
        end
        default: tx_state_reg <= ST_IDLE;
      endcase
      if (done_run_reg && !(tx_state_reg == ST_END && push_fire &&
          !tx_kind_reg)) begin
        if (done_cnt_reg == DONE_LAST) begin
          done_run_reg <= 1'b0;
          done_pend_reg <= 1'b1;
        end else begin
          done_cnt_reg <= done_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      // a request arriving as the last one is taken still wins
      if (rx_valid && rx_in_frame_reg && !rx_esc_reg &&
          rx_data == `SFL_END_BYTE && frame_good &&
          rx_op_reg == `SFL_OP_MULTI) begin
        resp_pend_reg <= 1'b1;
      end
    end
  end

  sfl_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_data(push_data),
    .in_ready(push_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_take)
  );

  assign fifo_take = !tx_valid || tx_ready;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (fifo_take) begin
      tx_valid <= fifo_valid;
      if (fifo_valid) begin
        tx_data <= fifo_data;
      end
    end
  end
endmodule // sfl_framer

// ==== rtl/sfl_regs.vh ====
// constants for the serial splice message framer
`ifndef SFL_REGS_VH
`define SFL_REGS_VH

// serial frame layer bytes
`define SFL_START_BYTE 8'h02
`define SFL_END_BYTE 8'h03
`define SFL_ESC_BYTE 8'h1b

// operation codes and sizes
`define SFL_OP_MULTI 16'hffff
`define SFL_OP_SPLICE 16'h0101
`define SFL_SPLICE_LEN 16'h000e
`define SFL_OP_INJ_RESP 16'h0007
`define SFL_OP_INJ_DONE 16'h0008
`define SFL_SIZE_RESP 16'h000e
`define SFL_SIZE_DONE 16'h000f
`define SFL_RES_OK 16'h0064
`define SFL_RES_PROXY 16'h0080
`define SFL_RES_EXT 16'h0000
`define SFL_PROTO_VER 8'h00

// field offsets inside a received multi-operation message
`define SFL_RX_OFF_OP_HI 8'h00
`define SFL_RX_OFF_OP_LO 8'h01
`define SFL_RX_OFF_AS 8'h05
`define SFL_RX_OFF_NUM 8'h06
`define SFL_RX_OFF_DPI_HI 8'h07
`define SFL_RX_OFF_DPI_LO 8'h08
`define SFL_RX_OFF_TS 8'h0a
`define SFL_RX_OFF_NOPS 8'h0b
`define SFL_RX_MIN_LEN 8'h10
`define SFL_TS_NONE 8'h00

// field offsets inside a sent reply
`define SFL_TX_OFF_RES_EXT 4'h6
`define SFL_TX_OFF_VER 4'h8
`define SFL_TX_OFF_NUM 4'ha
`define SFL_TX_OFF_DATA0 4'hd
`define SFL_TX_OFF_DATA1 4'he

// crc, mpeg-2 style, no reflection, no final xor
`define SFL_CRC_POLY 32'h04c11db7
`define SFL_CRC_INIT 32'hffffffff
`define SFL_CRC_RESIDUE 32'h00000000

// timing
`define SFL_CLK_KHZ 10000
`define SFL_DONE_DELAY_MS 500
`define SFL_DONE_CYCLES (`SFL_DONE_DELAY_MS * `SFL_CLK_KHZ)

`endif

// ==== sim/sfl_checker.sv ====
// port assertions for the serial splice framer
`timescale 1ns/1ps
module sfl_checker (
  input wire clock,
  input wire rst_n,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire proxy_mode,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire rx_frame_ok,
  input wire rx_frame_err
);
  wire take = tx_valid && tx_ready;
  wire end_in = rx_valid && rx_data == 8'h03;
  reg esc_reg;
  reg frame_reg;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // escape and frame state of the accepted byte stream
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      esc_reg <= 1'b0;
      frame_reg <= 1'b0;
    end else if (take) begin
      esc_reg <= tx_data == 8'h1b && !esc_reg;
      if (!esc_reg && tx_data == 8'h02)
        frame_reg <= 1'b1;
      if (!esc_reg && tx_data == 8'h03)
        frame_reg <= 1'b0;
    end
  end
  a_hold_offer: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("offer dropped early");
  a_esc_next: assert property (take && esc_reg |->
    tx_data inside {8'h02, 8'h03, 8'h1b}) else $error("bad escape");
  a_start_first: assert property (take && !esc_reg && tx_data == 8'h02
    |-> !frame_reg) else $error("start inside frame");
  a_end_closes: assert property (take && !esc_reg && tx_data == 8'h03
    |-> frame_reg) else $error("end outside frame");
  a_body_framed: assert property (take |-> frame_reg ||
    tx_data == 8'h02) else $error("byte outside frame");
  a_ok_after_end: assert property (rx_frame_ok |-> $past(end_in))
    else $error("ok pulse without end byte");
  a_err_after_end: assert property (rx_frame_err |-> $past(end_in))
    else $error("err pulse without end byte");
  a_flags_apart: assert property (rx_frame_ok |-> !rx_frame_err ##1
    !rx_frame_ok) else $error("ok pulse malformed");
  a_reply_starts: assert property (rx_frame_ok |-> ##[1:400]
    (take && !esc_reg && tx_data == 8'h02)) else $error("no reply");
endmodule // sfl_checker

// ==== sim/sfl_srv_model.sv ====
// automation server model: sends request frames, drains replies
`timescale 1ns/1ps
module sfl_srv_model (
  input wire clock,
  output reg [7:0] rx_data,
  output reg rx_valid,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output reg tx_ready
);
  integer seed = 44960;
  reg slow = 1'b0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  // stalls the reply stream at random while slow
  always @(posedge clock)
    tx_ready <= !slow || ($random(seed) % 3 != 0);
  // one wire byte per cycle, data line toggled once released
  task send(input logic [7:0] w[$]);
    integer i;
    begin
      for (i = 0; i < w.size(); i = i + 1) begin
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_data <= w[i];
      end
      @(posedge clock);
      rx_valid <= 1'b0;
      rx_data <= ~w[w.size()-1];
    end
  endtask
endmodule // sfl_srv_model

// ==== sim/testbench.sv ====
// self-checking bench for the serial splice framer
`timescale 1ns/1ps
module testbench;
  localparam DONE = 50;
  reg clock;
  reg rst_n;
  reg proxy_mode;
  wire [7:0] rx_data;
  wire [7:0] tx_data;
  wire rx_valid, tx_valid, tx_ready, rx_frame_ok, rx_frame_err;
  integer seed = 44960;
  integer fail_count = 0;
  integer checks = 0;
  integer i;
  logic [7:0] fresh = 8'h00;
  logic [7:0] exp_q[$];
  logic [1:0] flag_q[$];
  sfl_framer #(.DONE_CYCLES(DONE)) i_sfl_framer (.clock(clock),
    .rst_n(rst_n), .rx_data(rx_data), .rx_valid(rx_valid),
    .proxy_mode(proxy_mode), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_frame_ok(rx_frame_ok),
    .rx_frame_err(rx_frame_err));
  sfl_srv_model i_sfl_srv_model (.clock(clock), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cmp_flag(input logic [1:0] got, input logic [1:0] exp);
    begin
      cmp_byte({6'h00, got}, {6'h00, exp});
    end
  endtask
  always @(posedge clock) begin
    if (rst_n && tx_valid && tx_ready)
      cmp_byte(tx_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    if (rst_n && (rx_frame_ok || rx_frame_err))
      cmp_flag({rx_frame_ok, rx_frame_err},
        flag_q.size() ? flag_q.pop_front() : 2'bxx);
  end
  // body plus crc, escaped and delimited
  task automatic wrap(input logic [7:0] b[$], input bit bad,
    output logic [7:0] w[$]);
    logic [31:0] c;
    integer k;
    begin
      c = 32'hffffffff;
      foreach (b[j])
        for (k = 7; k >= 0; k--)
          c = {c[30:0], 1'b0} ^ ((c[31] ^ b[j][k]) ? 32'h04c11db7 : 0);
      c[0] = c[0] ^ bad;
      for (k = 3; k >= 0; k--)
        b.push_back(c[8*k +: 8]);
      w = {8'h02};
      foreach (b[j]) begin
        if (b[j] inside {8'h02, 8'h03, 8'h1b})
          w.push_back(8'h1b);
        w.push_back(b[j]);
      end
      w.push_back(8'h03);
    end
  endtask
  // bad: 0 good, 1 corrupt crc, 2 short body, 3 foreign opcode,
  // 4 good frame behind junk and an aborted start
  task automatic request(input logic [7:0] num, input int nops,
    input int ts, input bit px, input int bad);
    logic [7:0] b[$], w[$], r[$], x[$];
    logic [15:0] res;
    integer k, cx, gap;
    begin
      cx = 0;
      res = px ? 16'h0080 : 16'h0064;
      b = {8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h02, num, 8'h03,
        8'h1b, 8'h00, 8'(ts)};
      if (ts != 0)
        b.push_back(8'h11);
      b.push_back(8'(nops));
      for (k = 0; k < nops; k++) begin
        b = {b, 8'h01, 8'h01, 8'h00, 8'h0e};
        repeat (14) b.push_back(8'($random(seed)));
      end
      b[3] = 8'(b.size());
      if (bad == 2)
        b = b[0:7];
      if (bad == 3)
        b[0] = 8'h01;
      wrap(b, bad == 1, w);
      if (bad == 4)
        w = {8'h55, 8'h02, 8'hff, w};
      if (bad == 1 || bad == 2)
        flag_q.push_back(2'b01);
      else if (bad != 3) begin
        flag_q.push_back(2'b10);
        r = {8'h00, 8'h07, 8'h00, 8'h0e, res[15:8], res[7:0], 8'h00,
          8'h00, 8'h00, 8'h02, num, 8'h03, 8'h1b, num};
        wrap(r, 0, x);
        exp_q = {exp_q, x};
        if (fresh == num)
          fresh++;
        r = {8'h00, 8'h08, 8'h00, 8'h0f, res[15:8], res[7:0], 8'h00,
          8'h00, 8'h00, 8'h02, fresh, 8'h03, 8'h1b, num, 8'(nops)};
        fresh++;
        wrap(r, 0, x);
        cx = x.size();
        exp_q = {exp_q, x};
      end
      @(posedge clock);
      proxy_mode <= px;
      i_sfl_srv_model.send(w);
      k = 0;
      gap = 0;
      while (exp_q.size() != 0 && k < 3000) begin
        @(posedge clock);
        k++;
        if (exp_q.size() == cx)
          gap++;
      end
      repeat (5) @(posedge clock);
      cmp_byte(8'(exp_q.size() + flag_q.size()), 8'h00);
      if (cx != 0)
        cmp_byte(8'(gap > DONE - 30 && gap < DONE + 60), 8'h01);
    end
  endtask
  task print_verdict;
    begin
      if (fail_count == 0 && checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    rst_n = 1'b0;
    proxy_mode = 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    request(8'($random(seed)), 1, 0, 0, 0);
    request(fresh, 2, 1, 1, 0);
    request(8'h03, 0, 0, 0, 1);
    request(8'h1b, 1, 0, 1, 2);
    request(8'h55, 1, 0, 0, 3);
    request(8'($random(seed)), 1, 1, 0, 4);
    i_sfl_srv_model.slow <= 1'b1;
    for (i = 0; i < 6; i++)
      request(8'($random(seed)), i % 3, i % 2, i % 2, 0);
    print_verdict;
  end
  initial begin
    #(100 * 30000);
    fail_count = fail_count + 1;
    print_verdict;
  end
endmodule // testbench
bind sfl_framer sfl_checker i_sfl_checker (.clock(clock), .rst_n(rst_n),
  .rx_data(rx_data), .rx_valid(rx_valid), .proxy_mode(proxy_mode),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .rx_frame_ok(rx_frame_ok), .rx_frame_err(rx_frame_err));
